/* File: src/event_ctrl_pkg.sv */
package event_ctrl_pkg;

   // Sizes of the two stages.
   localparam int LEVELS      = 16;
   localparam int SOURCES     = 32;
   localparam int DEDICATED   = 7;
   localparam int GENERAL     = 9;
   localparam int ASSIGN_REGS = 4;
   localparam int LEVEL_W     = 4;

   // Cycle figures of the event path.
   localparam int EDGE_DETECT_CYCLES  = 2;
   localparam int MIN_PENDING_LATENCY = 3;

   // Register indices on the register port.
   localparam logic [3:0] IDX_CORE_LATCH   = 4'h0;
   localparam logic [3:0] IDX_CORE_MASK    = 4'h1;
   localparam logic [3:0] IDX_CORE_PENDING = 4'h2;
   localparam logic [3:0] IDX_SYS_MASK     = 4'h3;
   localparam logic [3:0] IDX_SYS_STATUS   = 4'h4;
   localparam logic [3:0] IDX_SYS_WAKEUP   = 4'h5;
   localparam logic [3:0] IDX_ASSIGN_FIRST = 4'h6;
   localparam logic [3:0] IDX_ASSIGN_LAST  = 4'h9;

   // Values after reset.
   localparam logic [15:0] CORE_LATCH_RESET   = 16'h0000;
   localparam logic [15:0] CORE_MASK_RESET    = 16'h0000;
   localparam logic [15:0] CORE_PENDING_RESET = 16'h0000;
   localparam logic [31:0] SYS_MASK_RESET     = 32'h00000000;
   localparam logic [31:0] SYS_WAKEUP_RESET   = 32'h00000000;
   localparam logic        GLOBAL_EN_RESET    = 1'b0;

   // Default routing, one nibble per source: general input = nibble, core level = 7 + nibble.
   localparam logic [127:0] ASSIGN_RESET = {32'h66655555, 32'h55555444,
                                            32'h43333332, 32'h22211000};

   // Value of the lowest set bit search when no bit is set.
   localparam logic [4:0] NO_LEVEL = 5'h10;

endpackage : event_ctrl_pkg

/* File: src/event_edge_detect.sv */
`timescale 1ns/10ps
`default_nettype none

module event_edge_detect #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Levels in, rising edges out
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] rise
);
   import event_ctrl_pkg::*;

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage1_next;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage2_next;

   generate
      if (WIDTH < 1 || EDGE_DETECT_CYCLES != 2) begin : g_bad_width
         $error("event_edge_detect: unsupported configuration");
      end
   endgenerate

   always_comb begin
      stage1_next = level_in;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   // The edge is seen one cycle after the level, the latch takes it one later.
   assign rise = stage1_reg & ~stage2_reg;

endmodule : event_edge_detect

`default_nettype wire

/* File: src/source_router.sv */
`timescale 1ns/10ps
`default_nettype none

module source_router #(
   parameter int SRC = 32,
   parameter int GEN = 9
) (
   // Routing table, one nibble per source
   input  wire logic [4*SRC-1:0] assign_map,
   // Per-source requests, already masked
   input  wire logic [SRC-1:0]   src_level,
   input  wire logic [SRC-1:0]   src_rise,
   // Newly set pending bits of the general inputs
   input  wire logic [GEN-1:0]   gen_ack,
   // Routed results
   output logic      [GEN-1:0]   gen_level,
   output logic      [GEN-1:0]   gen_rise,
   output logic      [SRC-1:0]   src_ack
);
   import event_ctrl_pkg::*;

   generate
      if (SRC < 1 || GEN < 1 || GEN > 16) begin : g_bad_size
         $error("source_router: unsupported configuration");
      end
   endgenerate

   genvar g;
   genvar s;
   generate
      for (g = 0; g < GEN; g++) begin : g_input
         always_comb begin
            gen_level[g] = 1'b0;
            gen_rise[g]  = 1'b0;
            for (int k = 0; k < SRC; k++) begin
               if (assign_map[4*k +: 4] == 4'(g)) begin
                  gen_level[g] = gen_level[g] | src_level[k];
                  gen_rise[g]  = gen_rise[g] | src_rise[k];
               end
            end
         end
      end
      for (s = 0; s < SRC; s++) begin : g_source
         // Codes beyond the last general input route nowhere and never ack.
         assign src_ack[s] = src_level[s] && (int'(assign_map[4*s +: 4]) < GEN)
                             && gen_ack[assign_map[4*s +: 4]];
      end
   endgenerate

endmodule : source_router

`default_nettype wire

/* File: src/two_stage_event_controller.sv */
`timescale 1ns/10ps
`default_nettype none

module two_stage_event_controller (
   // Clock and reset
   input  wire logic                                   clock,
   input  wire logic                                   rst_b,
   // Event sources
   input  wire logic [event_ctrl_pkg::SOURCES-1:0]     source_req,
   input  wire logic [event_ctrl_pkg::DEDICATED-1:0]   dedicated_req,
   // Processor core
   input  wire logic                                   supervisor,
   input  wire logic                                   core_idle,
   input  wire logic                                   service_accept,
   input  wire logic                                   event_return,
   input  wire logic                                   global_irq_enable_instr,
   input  wire logic                                   global_irq_disable_instr,
   output logic                                        service_req_reg,
   output logic      [event_ctrl_pkg::LEVEL_W-1:0]     service_level_reg,
   output logic      [event_ctrl_pkg::LEVELS-1:0]      core_event_pending_reg,
   output logic      [event_ctrl_pkg::GENERAL-1:0]     general_input_reg,
   output logic      [event_ctrl_pkg::SOURCES-1:0]     source_ack_reg,
   output logic                                        wakeup_reg,
   // Register port
   input  wire logic [3:0]                             reg_index,
   input  wire logic                                   reg_wr,
   input  wire logic                                   reg_rd,
   input  wire logic [31:0]                            reg_wdata,
   output logic      [31:0]                            reg_rdata_reg,
   output logic                                        reg_refused_reg
);
   import event_ctrl_pkg::*;
   logic [LEVELS-1:0]      core_event_latch_reg;
   logic [LEVELS-1:0]      core_event_latch_next;
   logic [LEVELS-1:0]      core_event_mask_reg;
   logic [LEVELS-1:0]      core_event_mask_next;
   logic [LEVELS-1:0]      core_event_pending_next;
   logic                   global_enable_reg;
   logic                   global_enable_next;
   logic [SOURCES-1:0]     system_source_mask_reg;
   logic [SOURCES-1:0]     system_source_mask_next;
   logic [SOURCES-1:0]     system_source_status_reg;
   logic [SOURCES-1:0]     system_wakeup_enable_reg;
   logic [SOURCES-1:0]     system_wakeup_enable_next;
   logic [4*SOURCES-1:0]   source_assignment_regs_reg;
   logic [4*SOURCES-1:0]   source_assignment_regs_next;
   logic                   service_req_next;
   logic [LEVEL_W-1:0]     service_level_next;
   logic [GENERAL-1:0]     general_input_next;
   logic [SOURCES-1:0]     source_ack_next;
   logic                   wakeup_next;
   logic [31:0]            reg_rdata_next;
   logic                   reg_refused_next;

   logic                   wr_ok;
   logic                   rd_ok;
   logic [SOURCES-1:0]     masked_src;
   logic [SOURCES-1:0]     src_rise;
   logic [DEDICATED-1:0]   ded_rise;
   logic [GENERAL-1:0]     gen_level;
   logic [GENERAL-1:0]     gen_rise;
   logic [LEVELS-1:0]      event_rise;
   logic [LEVELS-1:0]      accept_hit;
   logic [LEVELS-1:0]      return_clear;
   logic [LEVELS-1:0]      pending_set;
   logic [LEVELS-1:0]      level_enable;
   logic [4:0]             active_level;
   logic [4:0]             next_active;
   logic [4:0]             cand_level;

   generate
      if (LEVELS != DEDICATED + GENERAL || SOURCES > 32 || MIN_PENDING_LATENCY < 3)
      begin : g_bad_config
         $error("two_stage_event_controller: inconsistent sizes");
      end
   endgenerate

   function automatic logic [4:0] lowest_set(input logic [LEVELS-1:0] bits);
      logic [4:0] found;
      found = NO_LEVEL;
      for (int i = LEVELS - 1; i >= 0; i--) begin
         if (bits[i]) begin
            found = 5'(i);
         end
      end
      return found;
   endfunction : lowest_set

   assign wr_ok = reg_wr && supervisor;
   assign rd_ok = reg_rd && supervisor;

   assign masked_src = source_req & system_source_mask_reg;

   event_edge_detect #(.WIDTH(SOURCES)) u_src_edge (
      .clock    (clock),
      .rst_b    (rst_b),
      .level_in (masked_src),
      .rise     (src_rise)
   );

   event_edge_detect #(.WIDTH(DEDICATED)) u_ded_edge (
      .clock    (clock),
      .rst_b    (rst_b),
      .level_in (dedicated_req),
      .rise     (ded_rise)
   );

   // Per-source edges survive sharing
   // Edges are taken per source before the merge, so a second source rising while
   // the shared input is already high still latches a fresh event.
   source_router #(.SRC(SOURCES), .GEN(GENERAL)) u_router (
      .assign_map (source_assignment_regs_reg),
      .src_level  (masked_src),
      .src_rise   (src_rise),
      .gen_ack    (pending_set[LEVELS-1:DEDICATED]),
      .gen_level  (gen_level),
      .gen_rise   (gen_rise),
      .src_ack    (source_ack_next)
   );

   assign event_rise = {gen_rise, ded_rise};

   assign accept_hit = (service_accept && service_req_reg) ?
                       (16'h0001 << service_level_reg) : 16'h0000;

   assign active_level = lowest_set(core_event_pending_reg);
   assign return_clear = (event_return && active_level != NO_LEVEL) ?
                         (16'h0001 << active_level[3:0]) : 16'h0000;

   always_comb begin
      core_event_pending_next = (core_event_pending_reg & ~return_clear) | accept_hit;
   end

   assign pending_set = core_event_pending_next & ~core_event_pending_reg;

   genvar b;
   generate
      for (b = 0; b < LEVELS; b++) begin : g_latch
         logic sw_hit;
         logic held;
         assign sw_hit = wr_ok && reg_index == IDX_CORE_LATCH && !core_event_mask_reg[b];
         assign held   = sw_hit ? reg_wdata[b] : core_event_latch_reg[b];
         // New edge wins over the accept clear
         assign core_event_latch_next[b] = (held && !accept_hit[b]) || event_rise[b];
      end
   endgenerate

   always_comb begin
      global_enable_next = global_enable_reg;
      if (global_irq_enable_instr) begin
         global_enable_next = 1'b1;
      end
      // Disable wins on a tie, so a racing pair leaves interrupts off.
      if (global_irq_disable_instr) begin
         global_enable_next = 1'b0;
      end
   end

   always_comb begin
      core_event_mask_next        = core_event_mask_reg;
      system_source_mask_next     = system_source_mask_reg;
      system_wakeup_enable_next   = system_wakeup_enable_reg;
      source_assignment_regs_next = source_assignment_regs_reg;
      if (wr_ok) begin
         case (reg_index)
            IDX_CORE_MASK:  core_event_mask_next      = reg_wdata[LEVELS-1:0];
            IDX_SYS_MASK:   system_source_mask_next   = reg_wdata[SOURCES-1:0];
            IDX_SYS_WAKEUP: system_wakeup_enable_next = reg_wdata[SOURCES-1:0];
            default: begin
               if (reg_index >= IDX_ASSIGN_FIRST && reg_index <= IDX_ASSIGN_LAST) begin
                  source_assignment_regs_next[32*(reg_index - IDX_ASSIGN_FIRST) +: 32] =
                     reg_wdata;
               end
            end
         endcase
      end
   end

   // Mask and global gating of service
   assign level_enable = core_event_mask_next &
                         {{GENERAL{global_enable_next}}, {DEDICATED{1'b1}}};
   assign cand_level   = lowest_set(core_event_latch_next & level_enable);
   assign next_active  = lowest_set(core_event_pending_next);
   // Registered offer sets the minimum latency
   // Only a strictly higher level preempts
   always_comb begin
      service_req_next   = (cand_level != NO_LEVEL) && (cand_level < next_active);
      service_level_next = service_req_next ? cand_level[3:0] : service_level_reg;
   end

   always_comb begin
      general_input_next = gen_level;
      wakeup_next        = core_idle && |(source_req & system_wakeup_enable_reg);
   end

   always_comb begin
      reg_rdata_next   = 32'h00000000;
      reg_refused_next = (reg_rd || reg_wr) && !supervisor;
      if (rd_ok) begin
         case (reg_index)
            IDX_CORE_LATCH:   reg_rdata_next = {16'h0000, core_event_latch_reg};
            IDX_CORE_MASK:    reg_rdata_next = {16'h0000, core_event_mask_reg};
            IDX_CORE_PENDING: reg_rdata_next = {16'h0000, core_event_pending_reg};
            IDX_SYS_MASK:     reg_rdata_next = system_source_mask_reg;
            IDX_SYS_STATUS:   reg_rdata_next = system_source_status_reg;
            IDX_SYS_WAKEUP:   reg_rdata_next = system_wakeup_enable_reg;
            default: begin
               if (reg_index >= IDX_ASSIGN_FIRST && reg_index <= IDX_ASSIGN_LAST) begin
                  reg_rdata_next =
                     source_assignment_regs_reg[32*(reg_index - IDX_ASSIGN_FIRST) +: 32];
               end else begin
                  reg_refused_next = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         core_event_latch_reg       <= CORE_LATCH_RESET;
         core_event_mask_reg        <= CORE_MASK_RESET;
         core_event_pending_reg     <= CORE_PENDING_RESET;
         global_enable_reg          <= GLOBAL_EN_RESET;
         system_source_mask_reg     <= SYS_MASK_RESET;
         system_source_status_reg   <= '0;
         system_wakeup_enable_reg   <= SYS_WAKEUP_RESET;
         source_assignment_regs_reg <= ASSIGN_RESET;
         service_req_reg            <= 1'b0;
         service_level_reg          <= '0;
         general_input_reg          <= '0;
         source_ack_reg             <= '0;
         wakeup_reg                 <= 1'b0;
         reg_rdata_reg              <= 32'h00000000;
         reg_refused_reg            <= 1'b0;
      end else begin
         core_event_latch_reg       <= core_event_latch_next;
         core_event_mask_reg        <= core_event_mask_next;
         core_event_pending_reg     <= core_event_pending_next;
         global_enable_reg          <= global_enable_next;
         system_source_mask_reg     <= system_source_mask_next;
         // Bit position is the source identifier
         system_source_status_reg   <= source_req;
         system_wakeup_enable_reg   <= system_wakeup_enable_next;
         source_assignment_regs_reg <= source_assignment_regs_next;
         service_req_reg            <= service_req_next;
         service_level_reg          <= service_level_next;
         general_input_reg          <= general_input_next;
         source_ack_reg             <= source_ack_next;
         wakeup_reg                 <= wakeup_next;
         reg_rdata_reg              <= reg_rdata_next;
         reg_refused_reg            <= reg_refused_next;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_latch_on_edge: assert property (
      (event_rise != 16'h0000) |=> ((core_event_latch_reg & $past(event_rise)) ==
                                    $past(event_rise)))
      else $error("latch bit missed a detected edge");

   a_latch_sw_gate: assert property (
      (wr_ok && reg_index == IDX_CORE_LATCH) |=>
      ((core_event_latch_reg & $past(core_event_mask_reg)) ==
       ((($past(core_event_latch_reg) & ~$past(accept_hit)) | $past(event_rise)) &
        $past(core_event_mask_reg))))
      else $error("latch write changed an unmasked bit");

   a_mask_super_only: assert property (
      (reg_wr && !supervisor) |=> (core_event_mask_reg == $past(core_event_mask_reg))
                                  && reg_refused_reg)
      else $error("user-mode write was not refused");

   a_offer_unmasked: assert property (
      service_req_reg |-> core_event_mask_reg[service_level_reg])
      else $error("masked level offered");

   a_offer_global_en: assert property (
      (service_req_reg && service_level_reg >= 4'h7) |-> global_enable_reg)
      else $error("general level offered while globally disabled");

   a_accept_pends: assert property (
      (service_accept && service_req_reg) |=>
      core_event_pending_reg[$past(service_level_reg)] &&
      (core_event_latch_reg[$past(service_level_reg)] ==
       $past(event_rise[service_level_reg])))
      else $error("accept did not move latch to pending");

   a_nest_priority: assert property (
      service_req_reg |-> ({1'b0, service_level_reg} < active_level))
      else $error("offer does not outrank active level");

   a_min_latency: assert property (
      ($rose(dedicated_req[0]) && !core_event_latch_reg[0] && !service_req_reg &&
       !core_event_pending_reg[0]) |-> !core_event_pending_reg[0] [*3])
      else $error("pending rose sooner than three cycles");

   a_status_track: assert property (
      ##1 system_source_status_reg == $past(source_req))
      else $error("status does not follow sources");

   a_wakeup_on_idle: assert property (
      (core_idle && |(source_req & system_wakeup_enable_reg)) |=> wakeup_reg)
      else $error("enabled source failed to wake");

   a_ack_from_pend: assert property (
      (source_ack_reg != 32'h00000000) |->
      ((core_event_pending_reg & ~$past(core_event_pending_reg)) != 16'h0000))
      else $error("ack without a newly set pending bit");

   c_accept: cover property (service_accept && service_req_reg);
   c_nested: cover property (service_req_reg && core_event_pending_reg != 16'h0000);
   c_requeue: cover property ((core_event_latch_reg & core_event_pending_reg) != 16'h0000);
   c_wakeup: cover property (wakeup_reg);

endmodule : two_stage_event_controller

`default_nettype wire

/* File: tb/core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module core_model (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // Offer from the controller and bench commands
   input  wire logic service_req_reg,
   input  wire logic accept_en,
   input  wire logic ret_go,
   // Core answers
   output logic      service_accept,
   output logic      event_return
);
   // Taking the offer straight away gives the shortest legal latency.
   assign service_accept = accept_en & service_req_reg;

   always_ff @(posedge clock) begin
      event_return <= rst_b & ret_go;
   end
endmodule : core_model

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import event_ctrl_pkg::*;
   logic        clock, rst_b, supervisor, core_idle, g_en, g_dis;
   logic        reg_wr, reg_rd, accept_en, ret_go, acc, ev_ret;
   logic        srv_req, refused, wake;
   logic [3:0]  reg_index, srv_lvl;
   logic [6:0]  ded;
   logic [8:0]  gin;
   logic [15:0] pend;
   logic [31:0] source_req, reg_wdata, rdata, ack, rd;
   int          fails, n_compared;

   two_stage_event_controller dut (.clock(clock), .rst_b(rst_b), .source_req(source_req),
      .dedicated_req(ded), .supervisor(supervisor), .core_idle(core_idle),
      .service_accept(acc), .event_return(ev_ret), .global_irq_enable_instr(g_en),
      .global_irq_disable_instr(g_dis), .service_req_reg(srv_req),
      .service_level_reg(srv_lvl), .core_event_pending_reg(pend),
      .general_input_reg(gin), .source_ack_reg(ack), .wakeup_reg(wake),
      .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata_reg(rdata), .reg_refused_reg(refused));

   core_model core (.clock(clock), .rst_b(rst_b), .service_req_reg(srv_req),
      .accept_en(accept_en), .ret_go(ret_go), .service_accept(acc), .event_return(ev_ret));

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmp_port

   task automatic access(input logic wr, input logic [3:0] idx, input logic [31:0] d);
      @(posedge clock);
      reg_wr    <= wr;
      reg_rd    <= ~wr;
      reg_index <= idx;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 rd = rdata;
   endtask : access

   task automatic cmp_reg(input logic [3:0] idx, input logic [31:0] exp, input string what);
      access(1'b0, idx, 32'h00000000);
      cmp_port(rd, exp, what);
   endtask : cmp_reg

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic t_reset;
      for (int i = 0; i < 6; i++) cmp_reg(i[3:0], 32'h00000000, "reset value");
      cmp_reg(4'hA, 32'h00000000, "unmapped read");
      cmp_port(refused, 1'b1, "unmapped refused");
      @(posedge clock) supervisor <= 1'b0;
      access(1'b1, IDX_CORE_MASK, 32'h0000FFFF);
      cmp_port(refused, 1'b1, "user write refused");
      @(posedge clock) supervisor <= 1'b1;
      cmp_reg(IDX_CORE_MASK, 32'h00000000, "user write landed");
   endtask : t_reset

   task automatic t_gate;
      access(1'b1, IDX_SYS_MASK, 32'h00180001);
      access(1'b1, IDX_CORE_MASK, 32'h00001080);
      cmp_reg(IDX_CORE_MASK, 32'h00001080, "mask readback");
      @(posedge clock) source_req <= 32'h00000001;
      tick(4);
      cmp_port(srv_req, 1'b0, "offer while disabled");
      access(1'b1, IDX_CORE_LATCH, 32'h00000000);
      cmp_reg(IDX_CORE_LATCH, 32'h00000080, "latch write unmasked");
      access(1'b1, IDX_CORE_MASK, 32'h00001000);
      access(1'b1, IDX_CORE_LATCH, 32'h00000000);
      cmp_reg(IDX_CORE_LATCH, 32'h00000000, "latch write masked");
      @(posedge clock) source_req <= 32'h00000000;
   endtask : t_gate

   task automatic t_walk;
      @(posedge clock) g_en <= 1'b1;
      @(posedge clock) g_en <= 1'b0;
      source_req <= 32'h00080000;
      tick(1);
      cmp_port(srv_req, 1'b0, "offer too early");
      tick(1);
      cmp_port(srv_req, 1'b1, "offer raised");
      cmp_port(srv_lvl, 4'hC, "offered level");
      cmp_port(gin, 9'h020, "routed input");
      tick(1);
      cmp_port(pend, 16'h1000, "pending latency");
      // The acknowledge pulse rises together with the newly set pending bit.
      cmp_port(ack, 32'h00080000, "source ack");
      tick(1);
      cmp_port(ack, 32'h00000000, "ack stands one cycle");
      cmp_reg(IDX_CORE_LATCH, 32'h00000000, "latch after accept");
      cmp_reg(IDX_SYS_STATUS, 32'h00080000, "status bit");
      access(1'b1, IDX_CORE_MASK, 32'h00001001);
      @(posedge clock) ded <= 7'h01;
      tick(2);
      cmp_port(srv_lvl, 4'h0, "nested higher level");
      tick(1);
      cmp_port(pend, 16'h1001, "nested pending");
      @(posedge clock) ret_go <= 1'b1;
      ded <= 7'h00;
      @(posedge clock) ret_go <= 1'b0;
      tick(1);
      cmp_port(pend, 16'h1000, "return clears highest");
   endtask : t_walk

   task automatic t_queue;
      @(posedge clock) source_req <= 32'h00180000;
      tick(3);
      cmp_port(srv_req, 1'b0, "nested same level");
      cmp_reg(IDX_CORE_LATCH, 32'h00001000, "queued edge");
      @(posedge clock) ret_go <= 1'b1;
      @(posedge clock) ret_go <= 1'b0;
      tick(6);
      cmp_port(pend, 16'h1000, "queued accepted");
      cmp_reg(IDX_CORE_LATCH, 32'h00000000, "queue drained");
      @(posedge clock) ret_go <= 1'b1;
      accept_en <= 1'b0;
      @(posedge clock) ret_go <= 1'b0;
      tick(4);
      cmp_port(pend, 16'h0000, "pending after return");
   endtask : t_queue

   task automatic t_wake;
      access(1'b1, IDX_SYS_WAKEUP, 32'h00000020);
      @(posedge clock) core_idle <= 1'b1;
      source_req <= 32'h00180020;
      tick(1);
      cmp_port(wake, 1'b1, "wake-up");
      tick(2);
      cmp_port(gin, 9'h020, "masked source routed");
      cmp_reg(IDX_SYS_STATUS, 32'h00180020, "status of masked");
      // With the core not accepting, only the global disable can hold the offer back.
      @(posedge clock) g_dis <= 1'b1;
      @(posedge clock) g_dis <= 1'b0;
      source_req <= 32'h00000020;
      @(posedge clock) source_req <= 32'h00080020;
      tick(3);
      cmp_port(srv_req, 1'b0, "offer after global disable");
      cmp_reg(IDX_CORE_LATCH, 32'h00001000, "latched while disabled");
   endtask : t_wake

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      {rst_b, core_idle, g_en, g_dis, reg_wr, reg_rd, ret_go} = '0;
      {supervisor, accept_en} = 2'b11;
      {source_req, reg_wdata, reg_index, ded} = '0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      t_reset;
      t_gate;
      t_walk;
      t_queue;
      t_wake;
      conclude;
   end

   initial begin
      #(100 * 2000);
      fails++;
      conclude;
   end
endmodule : tb_top

`default_nettype wire
